// File: verilog/gpf_pkg.sv
// How it works
// - Forwarded pins are named on the link by a 5-bit ID, 32 possible.
// - Every sent state packet carries the input pin's send ID.
// - After reset both send and receive IDs of pin N equal N.
// - A pin sends changes only while forward_send_enable is 1; IDs 0 to 31.
// - Receiving pins follow only packets whose ID equals their receive ID.
// - All pins sharing a receive ID follow the same remote input.
// - ID forwarding works the same in both link directions.
// - Transitions are forwarded; a move to the held level changes nothing.
// - Without compensation changes go out as soon as the link accepts.
// - Serializer to deserializer: about 1us plain, 3.5us compensated.
// - Deserializer to serializer: about 6us plain, 15us compensated.
// - Bias select: 00 none, 01 pull-up, 10 pull-down, 11 reserved.
// - Bias strength bit: 1 weak resistance, 0 strong resistance.
// - output_driver_off 0 enables the driver, 1 leaves the pin undriven.
// - driver_style 0 is open-drain, 1 is push-pull.
// - With receive disabled the output follows manual_output_value.
// - Three registers per pin, consecutive in pin order from 0x200.
// - 20 pins: 15 input and output, 5 output-only that never send.
// - First register: bits 5,4,3,2,1,0 hold equalize, manual, level, recv, send, off.
// - Second register: bias 7:6, driver_style 5, send ID 4:0.
// - Third register: receive ID in bits 4:0.
// - The three-register layout repeats up to offset 0x23B.
package gpf_pkg;
  localparam int PIN_COUNT = 20;
  localparam int ID_W = 5;
  localparam logic [15:0] REG_BASE = 16'h0200;
  localparam logic [15:0] REG_LAST = 16'h023B;
  localparam logic [1:0] SUB_A = 2'h0;
  localparam logic [1:0] SUB_B = 2'h1;
  localparam logic [1:0] SUB_C = 2'h2;
  // First register fields
  localparam int A_STRENGTH = 7;
  localparam int A_EQUALIZE = 5;
  localparam int A_MANUAL = 4;
  localparam int A_LEVEL = 3;
  localparam int A_RECV_EN = 2;
  localparam int A_SEND_EN = 1;
  localparam int A_DRV_OFF = 0;
  localparam logic [7:0] A_WMASK = 8'hB7;
  // Second register fields
  localparam int B_BIAS_HI = 7;
  localparam int B_BIAS_LO = 6;
  localparam int B_STYLE = 5;
  // Reset values; the ID field is ORed with the pin index
  localparam logic [7:0] A_RESET = 8'h83;
  localparam logic [7:0] B_RESET = 8'hA0;
  localparam logic [7:0] C_RESET = 8'h40;
  // Bias resistor codes
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_UP = 2'h1;
  localparam logic [1:0] BIAS_DOWN = 2'h2;
  // Pins able to act as inputs; 13 to 17 are output-only
  localparam logic [PIN_COUNT-1:0] INPUT_CAPABLE = 20'hC1FFF;
  // Forwarding latency
  localparam int CLK_PERIOD_NS = 20;
  localparam int LAT_S2D_PLAIN_NS = 1000;
  localparam int LAT_S2D_COMP_NS = 3500;
  localparam int LAT_D2S_PLAIN_NS = 6000;
  localparam int LAT_D2S_COMP_NS = 15000;
  localparam int COMP_S2D_CYC = (LAT_S2D_COMP_NS - LAT_S2D_PLAIN_NS) / CLK_PERIOD_NS;
  localparam int COMP_D2S_CYC = (LAT_D2S_COMP_NS - LAT_D2S_PLAIN_NS) / CLK_PERIOD_NS;
  localparam int COMP_CNT_W = 9;
endpackage

// File: verilog/gpf_in_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gpf_in_sync #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw pins and synchronised result
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] changed
);
  logic [WIDTH-1:0] meta_q, meta_d;
  logic [WIDTH-1:0] sync_q, sync_d;
  logic [WIDTH-1:0] last_q, last_d;

  // Only the second stage and later feed logic, so a metastable first stage never reaches the edge detector
  always_comb begin
    meta_d = pin_raw;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign changed = sync_q ^ last_q;
endmodule
`default_nettype wire

// File: verilog/gpf_lat_delay.sv
`timescale 1ns/100ps
`default_nettype none
module gpf_lat_delay #(
  parameter int CNT_W = 9,
  parameter logic [8:0] EXTRA = 9'h07D
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Received transition
  input wire logic load,
  input wire logic load_level,
  input wire logic delay_en,
  // Regenerated level
  output logic level_q
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic pend_q, pend_d;
  logic level_d;

  // A newer transition restarts the wait, so the last one received always lands
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    pend_d = pend_q;
    level_d = level_q;
    if (load && !delay_en) begin
      level_d = load_level;
      busy_d = 1'b0;
    end else if (load) begin
      pend_d = load_level;
      cnt_d = EXTRA[CNT_W-1:0];
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        level_d = pend_q;
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      pend_q <= pend_d;
      level_q <= level_d;
    end
  end
endmodule
`default_nettype wire

// File: verilog/gpf_link_forward.sv
`timescale 1ns/100ps
`default_nettype none
module gpf_link_forward #(
  parameter int PINS = gpf_pkg::PIN_COUNT,
  parameter bit IS_SER = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Link send side
  output logic tx_valid,
  output logic [4:0] tx_pin_id,
  output logic tx_level,
  input wire logic tx_ready,
  // Link receive side
  input wire logic rx_valid,
  input wire logic [4:0] rx_pin_id,
  input wire logic rx_level,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pull_up_en,
  output logic [PINS-1:0] pull_dn_en,
  output logic [PINS-1:0] pull_weak
);
  localparam logic [8:0] EXTRA_CYC = IS_SER ? 9'(gpf_pkg::COMP_S2D_CYC)
                                            : 9'(gpf_pkg::COMP_D2S_CYC);

  logic [7:0] rega_q [PINS];
  logic [7:0] regb_q [PINS];
  logic [7:0] regc_q [PINS];
  logic [7:0] rega_d [PINS];
  logic [7:0] regb_d [PINS];
  logic [7:0] regc_d [PINS];
  logic [7:0] reg_rdata_d;
  logic reg_rvalid_d;
  logic [PINS-1:0] in_level;
  logic [PINS-1:0] in_changed;
  logic [PINS-1:0] pend_q, pend_d;
  logic [PINS-1:0] pend_lvl_q, pend_lvl_d;
  logic tx_valid_d;
  logic [4:0] tx_pin_id_d;
  logic tx_level_d;
  logic [PINS-1:0] rx_hit;
  logic [PINS-1:0] fwd_level;
  logic [PINS-1:0] pad_out_d, pad_oe_d, pull_up_d, pull_dn_d, pull_weak_d;
  logic hit;
  logic [1:0] hit_sub;
  int hit_pin;
  logic grant;
  int grant_pin;

  // Maps an address to its pin group and register within it
  function automatic logic [1:0] sub_of(input logic [15:0] addr, input int pin);
    logic [15:0] first;
    first = 16'(gpf_pkg::REG_BASE + 16'(3 * pin));
    if (addr == first) sub_of = gpf_pkg::SUB_A;
    else if (addr == first + 16'h0001) sub_of = gpf_pkg::SUB_B;
    else if (addr == first + 16'h0002) sub_of = gpf_pkg::SUB_C;
    else sub_of = 2'h3;
  endfunction

  gpf_in_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_raw(pad_in),
    .level(in_level),
    .changed(in_changed)
  );

  // Register decode and access
  always_comb begin
    hit = 1'b0;
    hit_sub = 2'h0;
    hit_pin = 0;
    for (int p = 0; p < PINS; p++) begin
      if (reg_addr <= gpf_pkg::REG_LAST && sub_of(reg_addr, p) != 2'h3) begin
        hit = 1'b1;
        hit_sub = sub_of(reg_addr, p);
        hit_pin = p;
      end
    end
    for (int p = 0; p < PINS; p++) begin
      rega_d[p] = rega_q[p];
      regb_d[p] = regb_q[p];
      regc_d[p] = regc_q[p];
    end
    if (reg_wr && hit) begin
      unique case (hit_sub)
        gpf_pkg::SUB_A: rega_d[hit_pin] = reg_wdata & gpf_pkg::A_WMASK;
        gpf_pkg::SUB_B: regb_d[hit_pin] = reg_wdata;
        gpf_pkg::SUB_C: regc_d[hit_pin] = reg_wdata;
        default: regc_d[hit_pin] = regc_q[hit_pin];
      endcase
    end
    reg_rvalid_d = reg_rd;
    reg_rdata_d = 8'h00;
    if (reg_rd && hit) begin
      unique case (hit_sub)
        gpf_pkg::SUB_A: begin
          reg_rdata_d = rega_q[hit_pin];
          reg_rdata_d[gpf_pkg::A_LEVEL] = in_level[hit_pin];
        end
        gpf_pkg::SUB_B: reg_rdata_d = regb_q[hit_pin];
        gpf_pkg::SUB_C: reg_rdata_d = regc_q[hit_pin];
        default: reg_rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int p = 0; p < PINS; p++) begin
        rega_q[p] <= gpf_pkg::A_RESET;
        regb_q[p] <= gpf_pkg::B_RESET | 8'(p);
        regc_q[p] <= gpf_pkg::C_RESET | 8'(p);
      end
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      for (int p = 0; p < PINS; p++) begin
        rega_q[p] <= rega_d[p];
        regb_q[p] <= regb_d[p];
        regc_q[p] <= regc_d[p];
      end
      reg_rdata <= reg_rdata_d;
      reg_rvalid <= reg_rvalid_d;
    end
  end

  // Send side: one pending slot per pin, lowest index first
  always_comb begin
    pend_d = pend_q;
    pend_lvl_d = pend_lvl_q;
    tx_valid_d = tx_valid;
    tx_pin_id_d = tx_pin_id;
    tx_level_d = tx_level;
    grant = 1'b0;
    grant_pin = 0;
    if (tx_valid && tx_ready) begin
      tx_valid_d = 1'b0;
    end
    if (!tx_valid_d) begin
      for (int p = PINS - 1; p >= 0; p--) begin
        if (pend_q[p]) begin
          grant = 1'b1;
          grant_pin = p;
        end
      end
    end
    if (grant) begin
      tx_valid_d = 1'b1;
      tx_pin_id_d = regb_q[grant_pin][gpf_pkg::ID_W-1:0];
      tx_level_d = pend_lvl_q[grant_pin];
      pend_d[grant_pin] = 1'b0;
    end
    // A change in the grant cycle wins over the clear, so it is never lost
    for (int p = 0; p < PINS; p++) begin
      if (in_changed[p] && rega_q[p][gpf_pkg::A_SEND_EN]
          && gpf_pkg::INPUT_CAPABLE[p]) begin
        pend_d[p] = 1'b1;
        pend_lvl_d[p] = in_level[p];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_q <= '0;
      pend_lvl_q <= '0;
      tx_valid <= 1'b0;
      tx_pin_id <= 5'h00;
      tx_level <= 1'b0;
    end else begin
      pend_q <= pend_d;
      pend_lvl_q <= pend_lvl_d;
      tx_valid <= tx_valid_d;
      tx_pin_id <= tx_pin_id_d;
      tx_level <= tx_level_d;
    end
  end

  // Receive side: every matching pin takes the packet, which gives broadcast
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_rx
      assign rx_hit[g] = rx_valid && rega_q[g][gpf_pkg::A_RECV_EN]
                         && rx_pin_id == regc_q[g][gpf_pkg::ID_W-1:0];
      gpf_lat_delay #(
        .CNT_W(gpf_pkg::COMP_CNT_W),
        .EXTRA(EXTRA_CYC)
      ) u_delay (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(rx_hit[g]),
        .load_level(rx_level),
        .delay_en(rega_q[g][gpf_pkg::A_EQUALIZE]),
        .level_q(fwd_level[g])
      );
    end
  endgenerate

  // Pad drivers and bias, all registered
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      pad_out_d[p] = rega_q[p][gpf_pkg::A_RECV_EN] ? fwd_level[p]
                                                    : rega_q[p][gpf_pkg::A_MANUAL];
      // Open-drain only sinks, so a high level releases the pin
      pad_oe_d[p] = !rega_q[p][gpf_pkg::A_DRV_OFF]
                    && (regb_q[p][gpf_pkg::B_STYLE] || !pad_out_d[p]);
      pull_up_d[p] = regb_q[p][gpf_pkg::B_BIAS_HI:gpf_pkg::B_BIAS_LO] == gpf_pkg::BIAS_UP;
      pull_dn_d[p] = regb_q[p][gpf_pkg::B_BIAS_HI:gpf_pkg::B_BIAS_LO] == gpf_pkg::BIAS_DOWN;
      pull_weak_d[p] = rega_q[p][gpf_pkg::A_STRENGTH];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe <= '0;
      pull_up_en <= '0;
      pull_dn_en <= '0;
      pull_weak <= '0;
    end else begin
      pad_out <= pad_out_d;
      pad_oe <= pad_oe_d;
      pull_up_en <= pull_up_d;
      pull_dn_en <= pull_dn_d;
      pull_weak <= pull_weak_d;
    end
  end
endmodule
`default_nettype wire

// File: tb/gpf_link_forward_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module gpf_link_forward_assertions #(
  parameter int PINS = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Link
  input wire logic tx_valid,
  input wire logic [4:0] tx_pin_id,
  input wire logic tx_level,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [4:0] rx_pin_id,
  input wire logic rx_level,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pull_up_en,
  input wire logic [PINS-1:0] pull_dn_en,
  input wire logic [PINS-1:0] pull_weak
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Two sync flops plus the read edge need four quiet cycles
  sequence s_pins_settled;
    $stable(pad_in) [*4];
  endsequence
  sequence s_read_first;
    reg_rd && reg_addr >= 16'h0200 && reg_addr <= 16'h023B && (reg_addr - 16'h0200) % 3 == 0;
  endsequence
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read without answer");
  a_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 16'h0200 || reg_addr > 16'h023B)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_bit6_zero: assert property (s_read_first |=> !reg_rdata[6])
    else $error("reserved bit set");
  a_level_read: assert property (s_pins_settled ##0 (reg_rd && reg_addr == 16'h0200)
    |=> reg_rdata[3] == $past(pad_in[0])) else $error("input level wrong");
  a_bias_excl: assert property ((pull_up_en & pull_dn_en) == '0)
    else $error("pull-up and pull-down together");
  a_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_pin_id) && $stable(tx_level)) else $error("packet dropped");
  a_reset_pads: assert property ($rose(rst_n)
    |-> ##[0:2] (pull_dn_en == '1 && pull_weak == '1 && pad_oe == '0)) else $error("reset pads");
endmodule
bind gpf_link_forward gpf_link_forward_assertions #(.PINS(PINS)) gpf_link_forward_assertions_inst (
  .clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .tx_valid,
  .tx_pin_id, .tx_level, .tx_ready, .rx_valid, .rx_pin_id, .rx_level, .pad_in, .pad_out, .pad_oe,
  .pull_up_en, .pull_dn_en, .pull_weak);
`default_nettype wire

// File: tb/gpf_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module gpf_far_end (
  // Clock
  input wire logic clk_sys,
  // Packets from the block
  input wire logic tx_valid,
  input wire logic [4:0] tx_pin_id,
  input wire logic tx_level,
  output logic tx_ready,
  // Packets to the block
  output logic rx_valid,
  output logic [4:0] rx_pin_id,
  output logic rx_level
);
  logic slow = 1'b0;
  int got_n = 0;
  logic [4:0] got_id;
  logic got_lvl;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_pin_id = 5'h00;
    rx_level = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      got_id <= tx_pin_id;
      got_lvl <= tx_level;
      got_n <= got_n + 1;
    end
    // A busy link grants only now and then
    tx_ready <= #1 slow ? ($urandom % 4 == 0) : 1'b1;
  end
  task automatic send(input logic [4:0] id, input logic lvl);
    @(posedge clk_sys);
    #1 rx_valid = 1'b1;
    rx_pin_id = id;
    rx_level = lvl;
    @(posedge clk_sys);
    #1 rx_valid = 1'b0;
    // Released lines do not keep the old packet
    rx_pin_id = ~id;
    rx_level = ~lvl;
  endtask
endmodule
`default_nettype wire

// File: tb/gpf_link_forward_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module gpf_link_forward_tb_top;
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, tx_valid, tx_level, tx_ready;
  logic rx_valid, rx_level;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, d;
  logic [4:0] tx_pin_id, rx_pin_id, id;
  logic [19:0] pad_in, pad_out, pad_oe, pull_up_en, pull_dn_en, pull_weak;
  int error_cnt = 0;
  int check_count = 0;
  int p, n0;
  gpf_link_forward gpf_link_forward_inst (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .tx_valid, .tx_pin_id, .tx_level, .tx_ready, .rx_valid, .rx_pin_id,
    .rx_level, .pad_in, .pad_out, .pad_oe, .pull_up_en, .pull_dn_en, .pull_weak);
  gpf_far_end gpf_far_end_inst (.clk_sys, .tx_valid, .tx_pin_id, .tx_level, .tx_ready, .rx_valid,
    .rx_pin_id, .rx_level);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input int a, input logic [7:0] v);
    reg_addr = 16'(a);
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rdr(input int a);
    reg_addr = 16'(a);
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1 rd = reg_rdata;
    chk("rvalid", 20'h00001, {19'h0, reg_rvalid});
    reg_rd = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [7:0] exp_rst(int a);
    if (a < 16'h0200 || a > 16'h023B) return 8'h00;
    if ((a - 16'h0200) % 3 == 0) return 8'h83;
    return ((a - 16'h0200) % 3 == 1 ? 8'hA0 : 8'h40) | 8'((a - 16'h0200) / 3);
  endfunction
  function automatic logic [7:0] exp_wr(int s, logic [7:0] v, logic lvl);
    return s == 0 ? (v & 8'hB7) | {4'h0, lvl, 3'h0} : v;
  endfunction
  task automatic wait_pkt();
    for (int i = 0; i < 200 && gpf_far_end_inst.got_n == n0; i++) @(posedge clk_sys);
    #1;
    // A packet that never arrives counts as a mismatch, not a stale pass
    chk("tx seen", 20'h00001, {19'h0, gpf_far_end_inst.got_n != n0});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, pad_in} = '0;
    void'($urandom(32'h67474B3C));
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    for (int a = 16'h01FF; a <= 16'h023C; a++) begin
      rdr(a);
      chk("reset reg", exp_rst(a), rd);
    end
    $display("reset map done");
    for (int c = 0; c < 4; c++) begin
      p = $urandom % 20;
      for (int s = 0; s < 3; s++) begin
        d = s == 1 ? {2'(c), 6'($urandom)} : 8'($urandom);
        wr(16'h0200 + 3 * p + s, d);
        rdr(16'h0200 + 3 * p + s);
        chk("rw reg", exp_wr(s, d, 1'b0), rd);
        if (s == 0) chk("weak", {19'h0, d[7]}, {19'h0, pull_weak[p]});
      end
      chk("pull up", {19'h0, c == 1}, {19'h0, pull_up_en[p]});
      chk("pull dn", {19'h0, c == 2}, {19'h0, pull_dn_en[p]});
    end
    $display("register access done");
    // Style and control byte per step, then expected enable and level
    for (int k = 0; k < 4; k++) begin
      d = k[1] ? 8'h23 : 8'h03;
      wr(16'h020A, d);
      d = k[0] ? 8'h10 : (k[1] ? 8'h11 : 8'h00);
      wr(16'h0209, d);
      chk("oe", {19'h0, ~d[0] & (k[1] | ~d[4])}, {19'h0, pad_oe[3]});
      if (!d[0]) chk("manual", {19'h0, d[4]}, {19'h0, pad_out[3]});
    end
    $display("driver test done");
    for (int i = 0; i < 4; i++) begin
      p = i == 0 ? 0 : $urandom % 15;
      if (p > 12) p += 5;
      id = 5'($urandom);
      gpf_far_end_inst.slow = i[0];
      wr(16'h0201 + 3 * p, {3'h0, id});
      wr(16'h0200 + 3 * p, 8'h03);
      n0 = gpf_far_end_inst.got_n;
      pad_in[p] = ~pad_in[p];
      wait_pkt();
      chk("tx id", {15'h0, id}, {15'h0, gpf_far_end_inst.got_id});
      chk("tx lvl", {19'h0, pad_in[p]}, {19'h0, gpf_far_end_inst.got_lvl});
      rdr(16'h0200 + 3 * p);
      chk("level", exp_wr(0, 8'h03, pad_in[p]), rd);
    end
    for (int j = 0; j < 2; j++) begin
      p = j == 0 ? 13 : 4;
      wr(16'h0200 + 3 * p, j == 0 ? 8'h03 : 8'h01);
      n0 = gpf_far_end_inst.got_n;
      pad_in[p] = ~pad_in[p];
      repeat (20) @(posedge clk_sys);
      #1 chk("no tx", n0, gpf_far_end_inst.got_n);
    end
    $display("send test done");
    id = 5'($urandom);
    for (int j = 0; j < 3; j++) wr(16'h0205 + 3 * j, {3'h0, id + 5'(j == 2)});
    for (int j = 0; j < 3; j++) wr(16'h0203 + 3 * j, 8'h04);
    for (int k = 0; k < 3; k++) begin
      gpf_far_end_inst.send(id, k != 2);
      repeat (2) @(posedge clk_sys);
      #1 chk("rx out", {17'h0, 1'b0, {2{k != 2}}}, {17'h0, pad_out[3:1]});
    end
    $display("receive test done");
    wr(16'h0203, 8'h24);
    gpf_far_end_inst.send(id, 1'b1);
    repeat (gpf_pkg::COMP_S2D_CYC - 20) @(posedge clk_sys);
    #1 chk("early", 20'h0, {19'h0, pad_out[1]});
    repeat (40) @(posedge clk_sys);
    #1 chk("late", 20'h1, {19'h0, pad_out[1]});
    $display("compensation test done");
    wrap_up();
  end
endmodule
`default_nettype wire
